// [design/arf_pkg.sv]
// Purpose: Shared constants and types of the async receive packet formatter.
// Assumes: Quadlets are 32 bits, transaction codes 4 bits.
// Notes:   Header quadlet counts are fixed here and used by the formatter.
`default_nettype none
package arf_pkg;
	// Transaction codes written into the receive FIFOs.
	localparam logic [3:0] TC_QWR_REQ  = 4'h0;
	localparam logic [3:0] TC_BWR_REQ  = 4'h1;
	localparam logic [3:0] TC_WR_RSP   = 4'h2;
	localparam logic [3:0] TC_QRD_REQ  = 4'h4;
	localparam logic [3:0] TC_BRD_REQ  = 4'h5;
	localparam logic [3:0] TC_QRD_RSP  = 4'h6;
	localparam logic [3:0] TC_BRD_RSP  = 4'h7;
	localparam logic [3:0] TC_CONFIRM  = 4'h8;
	localparam logic [3:0] TC_LOCK_REQ = 4'h9;
	localparam logic [3:0] TC_STREAM   = 4'ha;
	localparam logic [3:0] TC_LOCK_RSP = 4'hb;
	localparam logic [3:0] TC_SID_PHY  = 4'he;
	// Returned acknowledge codes.
	localparam logic [3:0] ACK_COMPLETE = 4'h1;
	localparam logic [3:0] ACK_PENDING  = 4'h2;
	localparam logic [3:0] ACK_BUSY_X   = 4'h4;
	localparam logic [3:0] ACK_BUSY_A   = 4'h5;
	localparam logic [3:0] ACK_BUSY_B   = 4'h6;
	localparam logic [3:0] ACK_DATA_ERR = 4'hd;
	// Stream reception status codes.
	localparam logic [3:0] STRM_OK  = 4'h1;
	localparam logic [3:0] STRM_ERR = 4'hd;
	// Header quadlet counts per format.
	localparam logic [1:0] HDR_N_NODATA  = 2'h3;
	localparam logic [1:0] HDR_N_QUADLET = 2'h0;
	localparam logic [1:0] HDR_N_SINGLE  = 2'h1;
	// Reset values, and bytes per quadlet.
	localparam logic [31:0] QUAD_RST  = 32'h0000_0000;
	localparam logic [15:0] LEN_RST   = 16'h0000;
	localparam logic [2:0]  BYTES_RST = 3'h0;
	localparam logic [2:0]  BYTES_Q   = 3'h4;

	// Kinds of entry delivered by the link layer.
	typedef enum logic [3:0] {
		ARF_K_PKT    = 4'b0001,
		ARF_K_SIDPHY = 4'b0010,
		ARF_K_CONF   = 4'b0100,
		ARF_K_STREAM = 4'b1000
	} arf_kind_e;

	// Received packet descriptor, valid after the packet has been checked.
	typedef struct packed {
		arf_kind_e   kind;
		logic [9:0]  dest_bus;
		logic [5:0]  dest_node;
		logic [5:0]  tlabel;
		logic [1:0]  rt;
		logic [3:0]  tcode;
		logic [3:0]  prio;
		logic [15:0] src_id;
		logic [15:0] offset_hi;
		logic [31:0] offset_lo;
		logic [3:0]  rcode;
		logic [31:0] quad_data;
		logic [15:0] data_length;
		logic [15:0] ext_tcode;
		logic [1:0]  tag;
		logic [5:0]  channel;
		logic [3:0]  sy;
		logic        crc_err;
		logic        conf_resp_fifo;
		logic [3:0]  conf_ack;
	} arf_desc_s;

	// One quadlet written to a receive FIFO.
	typedef struct packed {
		logic        resp_fifo;
		logic        last;
		logic [31:0] quad;
	} arf_quad_s;
endpackage : arf_pkg
`default_nettype wire

// [design/arf_tlabel_track.sv]
// Purpose: Keeps one outstanding bit per transaction label.
// Assumes: Labels are unique among active requests.
// Notes:   A set and a clear of the same label in one cycle leave it set.
`default_nettype none
module arf_tlabel_track #(
	parameter int LABELS = 64
) (
	input  wire logic                      core_clk, // System clock.
	input  wire logic                      rst_n,    // Async reset, low.
	input  wire logic                      ce,       // Clock enable.
	input  wire logic                      set_v,    // Request sent.
	input  wire logic [$clog2(LABELS)-1:0] set_lbl,  // Its label.
	input  wire logic                      clr_v,    // Response taken.
	input  wire logic [$clog2(LABELS)-1:0] clr_lbl,  // Its label.
	input  wire logic [$clog2(LABELS)-1:0] look_lbl, // Label looked up.
	output logic                           hit       // Label outstanding.
);
	logic [LABELS-1:0] out_q;
	logic [LABELS-1:0] out_d;

	always_comb begin
		out_d = out_q;
		if (clr_v) begin
			out_d[clr_lbl] = 1'b0;
		end
		if (set_v) begin
			out_d[set_lbl] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= '0;
		end else if (ce) begin
			out_q <= out_d;
		end
	end

	assign hit = out_q[look_lbl];
endmodule : arf_tlabel_track
`default_nettype wire

// [design/arf_formatter.sv]
// Purpose: Formats received asynchronous packets into receive FIFO quadlets.
// Assumes: Descriptor arrives after the packet is checked; bytes follow it.
// Notes:   One entry at a time; the FIFO side may stall through quad_ready.
//
// Overview of operation
// - Quadlet read request 4, quadlet write 0, read response 6, write resp 2.
// - Block read 5, block write 1, block read response 7, lock 9, lock resp B.
// - Self-ID and PHY entries form their own format with code E.
// - Transmit confirmations are written with transaction code 8.
// - Destination field is bus number then node number.
// - Transaction label is passed through unchanged.
// - Priority field is reported as received, 0000 on cable.
// - High and low offsets together address one local quadlet.
// - Zero byte length writes no block data quadlets.
// - First data byte lands in the top byte of the first quadlet.
// - Last quadlet is zero padded to a whole quadlet.
// - Unsolicited bit is one for responses matching no outstanding request.
// - Returned acknowledge code is recorded, even where none was sent.
// - Stream status is 0001 when good, 1101 on CRC error.
// - Retry code is delivered in the header.
// - Source node identifier is delivered in the source field.
// - Quadlet write and quadlet read response carry the payload quadlet.
// - Lock packets carry the extended transaction code.
// - Every request or response ends with one status quadlet.
// - Stream packets go to the response FIFO.
// - Ack codes 0001 complete, 0010 pending, 1101 data error, busy 01xx.
// - Self-ID and PHY entries open with a synthesized code E header.
`default_nettype none
module arf_formatter #(
	parameter int LABELS = 64
) (
	input  wire logic              core_clk,    // System clock, 10 MHz.
	input  wire logic              rst_n,       // Async reset, low.
	input  wire logic              ce,          // Clock enable.
	input  wire arf_pkg::arf_desc_s desc,       // Received packet descriptor.
	input  wire logic              desc_valid,  // Descriptor present.
	output logic                   desc_ready,  // Descriptor taken.
	input  wire logic [7:0]        byte_data,   // Payload byte.
	input  wire logic              byte_valid,  // Payload byte present.
	output logic                   byte_ready,  // Payload byte taken.
	input  wire logic              node_busy,   // Node refused the packet.
	input  wire logic              req_sent,    // Request left the node.
	input  wire logic [5:0]        req_label,   // Label of that request.
	output arf_pkg::arf_quad_s     quad_out,    // Quadlet for a FIFO.
	output logic                   quad_valid,  // Quadlet present.
	input  wire logic              quad_ready   // FIFO accepts quadlet.
);
	////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_HDR   = 4'b0010,
		ST_DATA  = 4'b0100,
		ST_TRAIL = 4'b1000
	} arf_state_e;

	arf_state_e         st_q,      st_d;
	arf_pkg::arf_desc_s dsc_q,     dsc_d;
	arf_pkg::arf_quad_s out_q,     out_d;
	logic               oval_q,    oval_d;
	logic               dready_q,  dready_d;
	logic               bready_q,  bready_d;
	logic [1:0]         idx_q,     idx_d;
	logic [15:0]        rem_q,     rem_d;
	logic [2:0]         nb_q,      nb_d;
	logic [31:0]        acc_q,     acc_d;
	logic               uns_q,     uns_d;
	logic [3:0]         ack_q,     ack_d;
	logic               slot_free;
	logic               take;
	logic               hit;
	logic               is_rsp;
	logic               rsp_take;

	////////////////////////////////////////////////////////////////////
	// Classifies descriptor codes.
	function automatic logic rsp_code(input logic [3:0] tc);
		rsp_code = (tc == arf_pkg::TC_WR_RSP) || (tc == arf_pkg::TC_QRD_RSP)
			|| (tc == arf_pkg::TC_BRD_RSP) || (tc == arf_pkg::TC_LOCK_RSP);
	endfunction : rsp_code

	// Number of header quadlets, zero standing for four.
	function automatic logic [1:0] hdr_n(input arf_pkg::arf_desc_s d);
		hdr_n = arf_pkg::HDR_N_SINGLE;
		if (d.kind == arf_pkg::ARF_K_PKT) begin
			if ((d.tcode == arf_pkg::TC_QRD_REQ)
				|| (d.tcode == arf_pkg::TC_WR_RSP)) begin
				hdr_n = arf_pkg::HDR_N_NODATA;
			end else begin
				hdr_n = arf_pkg::HDR_N_QUADLET;
			end
		end
	endfunction : hdr_n

	// Whether block data follows the header.
	function automatic logic has_blk(input arf_pkg::arf_desc_s d);
		has_blk = 1'b0;
		case (d.kind)
			arf_pkg::ARF_K_PKT: begin
				has_blk = (d.tcode == arf_pkg::TC_BWR_REQ)
					|| (d.tcode == arf_pkg::TC_BRD_RSP)
					|| (d.tcode == arf_pkg::TC_LOCK_REQ)
					|| (d.tcode == arf_pkg::TC_LOCK_RSP);
			end
			arf_pkg::ARF_K_SIDPHY: has_blk = 1'b1;
			arf_pkg::ARF_K_STREAM: has_blk = 1'b1;
			default: has_blk = 1'b0;
		endcase
	endfunction : has_blk

	// Header quadlet idx of the latched entry.
	function automatic logic [31:0] hdr_word(input arf_pkg::arf_desc_s d,
		input logic [1:0] idx);
		hdr_word = arf_pkg::QUAD_RST;
		case (d.kind)
			arf_pkg::ARF_K_PKT: begin
				case (idx)
					2'h0: hdr_word = {d.dest_bus, d.dest_node,
						d.tlabel, d.rt, d.tcode, d.prio};
					2'h1: hdr_word = rsp_code(d.tcode)
						? {d.src_id, d.rcode, 12'h000}
						: {d.src_id, d.offset_hi};
					2'h2: hdr_word = rsp_code(d.tcode)
						? arf_pkg::QUAD_RST : d.offset_lo;
					default: begin
						if ((d.tcode == arf_pkg::TC_QWR_REQ)
							|| (d.tcode == arf_pkg::TC_QRD_RSP)) begin
							hdr_word = d.quad_data;
						end else begin
							hdr_word = {d.data_length, d.ext_tcode};
						end
					end
				endcase
			end
			arf_pkg::ARF_K_SIDPHY: begin
				hdr_word = {24'h000000, arf_pkg::TC_SID_PHY, 4'h0};
			end
			arf_pkg::ARF_K_CONF: begin
				hdr_word = {16'h0000, d.tlabel, 2'h0,
					arf_pkg::TC_CONFIRM, 4'h0};
			end
			arf_pkg::ARF_K_STREAM: begin
				hdr_word = {d.data_length, d.tag, d.channel,
					arf_pkg::TC_STREAM, d.sy};
			end
			default: hdr_word = arf_pkg::QUAD_RST;
		endcase
	endfunction : hdr_word

	// Acknowledge code the node returned, or would have returned.
	function automatic logic [3:0] ack_of(input arf_pkg::arf_desc_s d,
		input logic busy);
		ack_of = arf_pkg::ACK_COMPLETE;
		if (d.kind == arf_pkg::ARF_K_CONF) begin
			ack_of = d.conf_ack;
		end else if (d.crc_err && has_blk(d)) begin
			ack_of = arf_pkg::ACK_DATA_ERR;
		end else if (busy && (d.kind == arf_pkg::ARF_K_PKT)) begin
			ack_of = arf_pkg::ACK_BUSY_X;
		end else if ((d.kind == arf_pkg::ARF_K_PKT) && !rsp_code(d.tcode)
			&& (d.tcode != arf_pkg::TC_QWR_REQ)
			&& (d.tcode != arf_pkg::TC_BWR_REQ)) begin
			ack_of = arf_pkg::ACK_PENDING;
		end
	endfunction : ack_of

	////////////////////////////////////////////////////////////////////
	// Outstanding request labels for the unsolicited flag.
	assign is_rsp   = (desc.kind == arf_pkg::ARF_K_PKT) && rsp_code(desc.tcode);
	assign take     = desc_valid && dready_q;
	assign rsp_take = take && is_rsp;

	arf_tlabel_track #(
		.LABELS   (LABELS)
	) u_track (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.set_v    (req_sent),
		.set_lbl  (req_label),
		.clr_v    (rsp_take),
		.clr_lbl  (desc.tlabel),
		.look_lbl (desc.tlabel),
		.hit      (hit)
	);

	////////////////////////////////////////////////////////////////////
	// Packet sequencer.
	assign slot_free = !oval_q || quad_ready;

	always_comb begin
		st_d   = st_q;
		dsc_d  = dsc_q;
		out_d  = out_q;
		oval_d = oval_q && !quad_ready;
		idx_d  = idx_q;
		rem_d  = rem_q;
		nb_d   = nb_q;
		acc_d  = acc_q;
		uns_d  = uns_q;
		ack_d  = ack_q;
		case (st_q)
			ST_IDLE: begin
				if (take) begin
					dsc_d = desc;
					uns_d = is_rsp && !hit;
					ack_d = ack_of(desc, node_busy);
					idx_d = 2'h0;
					nb_d  = arf_pkg::BYTES_RST;
					acc_d = arf_pkg::QUAD_RST;
					rem_d = has_blk(desc) ? desc.data_length
						: arf_pkg::LEN_RST;
					st_d  = ST_HDR;
				end
			end
			ST_HDR: begin
				if (slot_free) begin
					out_d.quad      = hdr_word(dsc_q, idx_q);
					out_d.last      = 1'b0;
					out_d.resp_fifo = (dsc_q.kind == arf_pkg::ARF_K_STREAM)
						|| ((dsc_q.kind == arf_pkg::ARF_K_PKT)
						&& rsp_code(dsc_q.tcode))
						|| ((dsc_q.kind == arf_pkg::ARF_K_CONF)
						&& dsc_q.conf_resp_fifo);
					oval_d = 1'b1;
					idx_d  = idx_q + 2'h1;
					if (idx_d == hdr_n(dsc_q)) begin
						st_d = (rem_q == arf_pkg::LEN_RST) ? ST_TRAIL
							: ST_DATA;
					end
				end
			end
			ST_DATA: begin
				if (byte_valid && bready_q) begin
					acc_d = {acc_q[23:0], byte_data};
					nb_d  = nb_q + 3'h1;
					rem_d = rem_q - 16'h0001;
				end else if ((nb_q != arf_pkg::BYTES_RST) && slot_free
					&& ((nb_q == arf_pkg::BYTES_Q)
					|| (rem_q == arf_pkg::LEN_RST))) begin
					// Short quadlet is shifted up, zero bytes fill below.
					out_d.quad = acc_q << {(arf_pkg::BYTES_Q - nb_q), 3'h0};
					out_d.last = 1'b0;
					oval_d     = 1'b1;
					nb_d       = arf_pkg::BYTES_RST;
					acc_d      = arf_pkg::QUAD_RST;
					if (rem_q == arf_pkg::LEN_RST) begin
						st_d = ST_TRAIL;
					end
				end
			end
			ST_TRAIL: begin
				if (slot_free) begin
					if (dsc_q.kind == arf_pkg::ARF_K_STREAM) begin
						out_d.quad = {28'h0000000, dsc_q.crc_err
							? arf_pkg::STRM_ERR : arf_pkg::STRM_OK};
					end else begin
						out_d.quad = {uns_q, 27'h0000000, ack_q};
					end
					out_d.last = 1'b1;
					oval_d     = 1'b1;
					st_d       = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		dready_d = (st_d == ST_IDLE);
		bready_d = (st_d == ST_DATA) && (nb_d != arf_pkg::BYTES_Q)
			&& (rem_d != arf_pkg::LEN_RST);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q     <= ST_IDLE;
			dsc_q    <= '0;
			out_q    <= '0;
			oval_q   <= 1'b0;
			dready_q <= 1'b0;
			bready_q <= 1'b0;
			idx_q    <= 2'h0;
			rem_q    <= arf_pkg::LEN_RST;
			nb_q     <= arf_pkg::BYTES_RST;
			acc_q    <= arf_pkg::QUAD_RST;
			uns_q    <= 1'b0;
			ack_q    <= 4'h0;
		end else if (ce) begin
			st_q     <= st_d;
			dsc_q    <= dsc_d;
			out_q    <= out_d;
			oval_q   <= oval_d;
			dready_q <= dready_d;
			bready_q <= bready_d;
			idx_q    <= idx_d;
			rem_q    <= rem_d;
			nb_q     <= nb_d;
			acc_q    <= acc_d;
			uns_q    <= uns_d;
			ack_q    <= ack_d;
		end
	end

	assign desc_ready = dready_q;
	assign byte_ready = bready_q;
	assign quad_out   = out_q;
	assign quad_valid = oval_q;
endmodule : arf_formatter
`default_nettype wire

// [dv/arf_formatter_props.sv]
// Purpose: Port assertions for the receive formatter.
// Assumes: One clock domain; ce is high in the bench.
// Notes:   Header checks look at the first quadlet after a take.
`default_nettype none
module arf_formatter_props #(
	parameter int LABELS = 64
) (
	input wire logic               core_clk,   // Clock.
	input wire logic               rst_n,      // Reset.
	input wire logic               ce,         // Enable.
	input wire arf_pkg::arf_desc_s desc,       // Descriptor.
	input wire logic               desc_valid, // Present.
	input wire logic               desc_ready, // Taken.
	input wire logic [7:0]         byte_data,  // Byte.
	input wire logic               byte_valid, // Present.
	input wire logic               byte_ready, // Taken.
	input wire logic               node_busy,  // Busy.
	input wire logic               req_sent,   // Sent.
	input wire logic [5:0]         req_label,  // Label.
	input wire arf_pkg::arf_quad_s quad_out,   // Quadlet.
	input wire logic               quad_valid, // Present.
	input wire logic               quad_ready  // Room.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	logic               take;
	arf_pkg::arf_desc_s cap_q;
	assign take = ce && desc_valid && desc_ready;
	// Keeps the taken descriptor for the header checks.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_q <= '0;
		end else if (take) begin
			cap_q <= desc;
		end
	end
	////////////////////////////////////////////////////////////////////////
	quad_hold_a: assert property (
		quad_valid && !quad_ready && ce |=> quad_valid && $stable(quad_out))
		else $error("quadlet changed before accept");
	take_drop_a: assert property (
		take |=> !desc_ready) else $error("second entry taken");
	pkt_hdr_a: assert property (
		take && desc.kind == arf_pkg::ARF_K_PKT |-> ##[1:2] quad_valid &&
		quad_out.quad[7:4] == cap_q.tcode &&
		quad_out.quad[15:10] == cap_q.tlabel &&
		quad_out.quad[31:22] == cap_q.dest_bus) else $error("bad header");
	sid_hdr_a: assert property (
		take && desc.kind == arf_pkg::ARF_K_SIDPHY |-> ##[1:2] quad_valid &&
		quad_out.quad == 32'h0000_00e0) else $error("bad self-id header");
	conf_hdr_a: assert property (
		take && desc.kind == arf_pkg::ARF_K_CONF |-> ##[1:2] quad_valid &&
		quad_out.quad == {16'h0000, cap_q.tlabel, 6'h08, 4'h0})
		else $error("bad confirmation");
	strm_fifo_a: assert property (
		take && desc.kind == arf_pkg::ARF_K_STREAM |-> ##[1:2] quad_valid &&
		quad_out.resp_fifo && quad_out.quad[7:4] == 4'ha &&
		quad_out.quad[31:16] == cap_q.data_length) else $error("bad stream");
	zero_len_a: assert property (
		take && desc.data_length == 16'h0000 |=> !byte_ready [*4])
		else $error("byte taken for empty entry");
	last_idle_a: assert property (
		$rose(quad_out.last) |-> quad_valid && desc_ready)
		else $error("no return to idle");
	cover property (take && desc.kind == arf_pkg::ARF_K_PKT);
	cover property (quad_valid && !quad_ready);
	cover property (byte_valid && byte_ready);
endmodule : arf_formatter_props
bind arf_formatter arf_formatter_props #(.LABELS(LABELS)) u_props (
	.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .desc(desc),
	.desc_valid(desc_valid), .desc_ready(desc_ready),
	.byte_data(byte_data), .byte_valid(byte_valid),
	.byte_ready(byte_ready), .node_busy(node_busy), .req_sent(req_sent),
	.req_label(req_label), .quad_out(quad_out), .quad_valid(quad_valid),
	.quad_ready(quad_ready));
`default_nettype wire

// [dv/arf_fifo_model.sv]
// Purpose: Receive FIFO reader that keeps every accepted quadlet.
// Assumes: One clock; slow stalls every other cycle.
// Notes:   Ready is changed only just after a rising edge.
`default_nettype none
module arf_fifo_model (
	input wire logic               core_clk,   // Clock.
	input wire logic               rst_n,      // Reset.
	input wire logic               slow,       // Stall mode.
	input wire arf_pkg::arf_quad_s quad_out,   // Quadlet.
	input wire logic               quad_valid, // Present.
	output logic                   quad_ready  // Room.
);
	timeunit 1ns;
	timeprecision 1ns;
	arf_pkg::arf_quad_s got[$];
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			quad_ready <= 1'b0;
		end else begin
			if (quad_valid && quad_ready) begin
				got.push_back(quad_out);
			end
			quad_ready <= slow ? ~quad_ready : 1'b1;
		end
	end
endmodule : arf_fifo_model
`default_nettype wire

// [dv/testbench.sv]
// Purpose: Self-checking bench of the receive formatter.
// Assumes: Bytes of an entry are 8'h10 upward.
// Notes:   Quadlets are compared as {resp_fifo, last, quad}.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic               core_clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               desc_valid = 1'b0;
	logic               byte_valid = 1'b0;
	logic               node_busy = 1'b0;
	logic               req_sent = 1'b0;
	logic               slow = 1'b0;
	logic [7:0]         byte_data = 8'h00;
	logic [5:0]         req_label = 6'h00;
	arf_pkg::arf_desc_s desc = '0;
	arf_pkg::arf_quad_s quad_out;
	logic               desc_ready;
	logic               byte_ready;
	logic               quad_valid;
	logic               quad_ready;
	int                 miscompares = 0;
	int                 total_checks = 0;
	int                 cycles = 0;
	arf_formatter u_dut (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
		.desc(desc), .desc_valid(desc_valid), .desc_ready(desc_ready),
		.byte_data(byte_data), .byte_valid(byte_valid),
		.byte_ready(byte_ready), .node_busy(node_busy),
		.req_sent(req_sent), .req_label(req_label), .quad_out(quad_out),
		.quad_valid(quad_valid), .quad_ready(quad_ready));
	arf_fifo_model u_fifo (.core_clk(core_clk), .rst_n(rst_n),
		.slow(slow), .quad_out(quad_out), .quad_valid(quad_valid),
		.quad_ready(quad_ready));
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	function automatic logic [33:0] g(input int i);
		return u_fifo.got[i];
	endfunction : g
	function automatic logic [31:0] hdr0(input arf_pkg::arf_desc_s d);
		return {d.dest_bus, d.dest_node, d.tlabel, d.rt, d.tcode, d.prio};
	endfunction : hdr0
	function automatic arf_pkg::arf_desc_s mk(input arf_pkg::arf_kind_e k,
		input logic [3:0] tc, input logic [15:0] len);
		arf_pkg::arf_desc_s d;
		d = '0;
		d.kind = k;
		d.tcode = tc;
		d.data_length = len;
		d.dest_bus = 10'h3ff;
		d.dest_node = 6'h3f;
		d.tlabel = 6'h2a;
		d.rt = 2'h1;
		d.prio = 4'h1;
		d.src_id = 16'hffc1;
		d.offset_hi = 16'hfffe;
		d.offset_lo = 32'hf000_0400;
		d.quad_data = 32'h1234_5678;
		return d;
	endfunction : mk
	task automatic wait_ready(input bit sel);
		int w;
		w = 0;
		do begin
			@(negedge core_clk);
			w++;
		end while ((sel ? byte_ready : desc_ready) !== 1'b1 && w < 500);
		@(posedge core_clk);
	endtask : wait_ready
	task automatic run(input arf_pkg::arf_desc_s d, input int nb, input int nq);
		int w;
		u_fifo.got.delete();
		@(posedge core_clk);
		desc <= d;
		desc_valid <= 1'b1;
		wait_ready(0);
		desc <= arf_pkg::arf_desc_s'(~d);
		desc_valid <= 1'b0;
		for (int k = 0; k < nb; k++) begin
			byte_data <= 8'h10 + 8'(k);
			byte_valid <= 1'b1;
			wait_ready(1);
		end
		byte_valid <= 1'b0;
		w = 0;
		while (u_fifo.got.size() < nq && w < 300) begin
			@(posedge core_clk);
			w++;
		end
		repeat (3) @(posedge core_clk);
		check(34'(u_fifo.got.size()), 34'(nq));
	endtask : run
	////////////////////////////////////////////////////////////////////////
	task automatic sc_quad_write();
		arf_pkg::arf_desc_s d;
		d = mk(arf_pkg::ARF_K_PKT, 4'h0, 16'h0000);
		run(d, 0, 5);
		check(g(0), {2'b00, hdr0(d)});
		check(g(1), {2'b00, d.src_id, d.offset_hi});
		check(g(2), {2'b00, d.offset_lo});
		check(g(3), {2'b00, d.quad_data});
		check(g(4), {2'b01, 32'h0000_0001});
		$display("quad write done");
	endtask : sc_quad_write
	task automatic sc_responses();
		arf_pkg::arf_desc_s d;
		slow <= 1'b1;
		d = mk(arf_pkg::ARF_K_PKT, 4'h2, 16'h0000);
		d.rcode = 4'h4;
		run(d, 0, 4);
		check(g(1), {2'b10, d.src_id, 4'h4, 12'h000});
		check(g(3), {2'b11, 32'h8000_0001});
		slow <= 1'b0;
		req_sent <= 1'b1;
		req_label <= 6'h15;
		@(posedge core_clk);
		req_sent <= 1'b0;
		d = mk(arf_pkg::ARF_K_PKT, 4'h6, 16'h0000);
		d.tlabel = 6'h15;
		run(d, 0, 5);
		check(g(3), {2'b10, d.quad_data});
		check(g(4), {2'b11, 32'h0000_0001});
		d = mk(arf_pkg::ARF_K_PKT, 4'h7, 16'h0004);
		d.tlabel = 6'h15;
		d.crc_err = 1'b1;
		run(d, 4, 6);
		check(g(4), {2'b10, 32'h1011_1213});
		check(g(5), {2'b11, 32'h8000_000d});
		$display("responses done");
	endtask : sc_responses
	task automatic sc_block();
		arf_pkg::arf_desc_s d;
		@(posedge core_clk);
		node_busy <= 1'b1;
		d = mk(arf_pkg::ARF_K_PKT, 4'h1, 16'h0005);
		run(d, 5, 7);
		node_busy <= 1'b0;
		check(g(3), {2'b00, 32'h0005_0000});
		check(g(4), {2'b00, 32'h1011_1213});
		check(g(5), {2'b00, 32'h1400_0000});
		check(g(6), {2'b01, 32'h0000_0004});
		d = mk(arf_pkg::ARF_K_PKT, 4'h9, 16'h0000);
		d.ext_tcode = 16'h0002;
		run(d, 0, 5);
		check(g(3), {2'b00, 32'h0000_0002});
		check(g(4), {2'b01, 32'h0000_0002});
		d = mk(arf_pkg::ARF_K_PKT, 4'h4, 16'h0000);
		run(d, 0, 4);
		check(g(0), {2'b00, hdr0(d)});
		check(g(3), {2'b01, 32'h0000_0002});
		d = mk(arf_pkg::ARF_K_PKT, 4'h5, 16'h0010);
		run(d, 0, 5);
		check(g(3), {2'b00, 32'h0010_0000});
		check(g(4), {2'b01, 32'h0000_0002});
		d = mk(arf_pkg::ARF_K_PKT, 4'hb, 16'h0002);
		d.ext_tcode = 16'h0002;
		run(d, 2, 6);
		check(g(3), {2'b10, 32'h0002_0002});
		check(g(4), {2'b10, 32'h1011_0000});
		check(g(5), {2'b11, 32'h8000_0001});
		$display("block done");
	endtask : sc_block
	task automatic sc_other();
		arf_pkg::arf_desc_s d;
		d = mk(arf_pkg::ARF_K_STREAM, 4'h0, 16'h0003);
		d.tag = 2'h1;
		d.channel = 6'h05;
		d.sy = 4'h3;
		d.crc_err = 1'b1;
		run(d, 3, 3);
		check(g(1), {2'b10, 32'h1011_1200});
		check(g(2), {2'b11, 32'h0000_000d});
		d.crc_err = 1'b0;
		d.data_length = 16'h0000;
		run(d, 0, 2);
		check(g(1), {2'b11, 32'h0000_0001});
		run(mk(arf_pkg::ARF_K_SIDPHY, 4'h0, 16'h0008), 8, 4);
		check(g(0), {2'b00, 32'h0000_00e0});
		check(g(2), {2'b00, 32'h1415_1617});
		check(g(3), {2'b01, 32'h0000_0001});
		d = mk(arf_pkg::ARF_K_CONF, 4'h0, 16'h0000);
		d.conf_resp_fifo = 1'b1;
		d.conf_ack = 4'h2;
		run(d, 0, 2);
		check(g(0), {2'b10, 16'h0000, 6'h2a, 6'h08, 4'h0});
		check(g(1), {2'b11, 32'h0000_0002});
		d.conf_resp_fifo = 1'b0;
		d.conf_ack = 4'h1;
		run(d, 0, 2);
		check(g(1), {2'b01, 32'h0000_0001});
		$display("stream, self-id, confirm done");
	endtask : sc_other
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		sc_quad_write();
		sc_responses();
		sc_block();
		sc_other();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
